// *** bench/kbm_host_model.sv ***
// Purpose: host-side i/o cycle model for the keyboard mailbox
// Assumes: strobes driven at the falling edge, one cycle long
// Notes: idle write data shows the inverse of the last written byte; each read cycle inverts it again
`timescale 1ns/1ps
module kbm_host_model
    import kbm_pkg::*;
(
    input wire logic mclk_in, // ec clock
    output kbm_host_req_t host_req_out, // i/o strobe
    input wire logic [7:0] host_rdata_in // read data
);
    // =====================================================
    // host i/o cycles
    initial host_req_out = '{1'b0, 1'b0, 3'h0, 8'h00};
    // one write cycle, data at index 0, command at index 4
    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        host_req_out = '{1'b1, 1'b0, idx, d};
        @(negedge mclk_in);
        host_req_out = '{1'b0, 1'b0, idx, ~d};
    endtask : wr
    // one read cycle, status at index 4
    task automatic rd(input logic [2:0] idx, output logic [7:0] d);
        host_req_out = '{1'b0, 1'b1, idx, ~host_req_out.wdata};
        @(negedge mclk_in);
        host_req_out.rd = 1'b0;
        d = host_rdata_in;
    endtask : rd
endmodule : kbm_host_model

// *** bench/kbm_mailbox_tb.sv ***
// Purpose: self-checking bench for the keyboard mailbox
// Assumes: host cycles come from the host model
// Notes: all stimulus lands on the falling edge
`timescale 1ns/1ps
module kbm_mailbox_tb
    import kbm_pkg::*;
;
    logic mclk;
    logic rst;
    kbm_host_req_t hreq;
    kbm_ec_req_t ereq;
    logic [7:0] hrd;
    logic [7:0] erd;
    logic [7:0] d;
    logic a20_wr, a20_val, fw_a20, hrdy, eirq, epulse, kline, mline, gate;
    int num_errors;
    int n_tests;

    kbm_mailbox uut (.mclk_in(mclk), .rst_in(rst), .host_req_in(hreq),
        .host_rdata_out(hrd), .ec_req_in(ereq), .ec_rdata_out(erd),
        .host_a20_wr_in(a20_wr), .host_a20_val_in(a20_val),
        .fw_a20_val_in(fw_a20), .host_ready_out(hrdy),
        .ec_input_full_irq_out(eirq), .ec_output_empty_irq_out(epulse),
        .keyboard_irq_line_out(kline), .mouse_irq_line_out(mline),
        .address_bit20_gate_out(gate));
    kbm_host_model host (.mclk_in(mclk), .host_req_out(hreq),
        .host_rdata_in(hrd));

    // =====================================================
    // tasks
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one ec bus cycle, strobe held one clock, then one idle clock
    task automatic ec_op(input logic w, input logic [9:0] a, input logic [7:0] v);
        ereq = '{w, !w, a, v};
        @(negedge mclk);
        ereq = '{1'b0, 1'b0, a, ~v};
        @(negedge mclk);
    endtask : ec_op
    task automatic ec_rd(input logic [9:0] a, input logic [7:0] e);
        ec_op(1'b0, a, 8'h00);
        chk($sformatf("ec read %h", a), e, erd);
    endtask : ec_rd
    // bits: input-full, keyboard, mouse, output-empty pulse
    task automatic lines(input logic [7:0] e);
        chk("irq lines", e, {4'h0, eirq, kline, mline, epulse});
    endtask : lines
    task automatic close_out;
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // clock and watchdog
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        #100us;
        num_errors++;
        close_out();
    end

    // =====================================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        ereq = '0;
        {a20_wr, a20_val, fw_a20} = 3'b000;
        num_errors = 0;
        n_tests = 0;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        ec_rd(KBM_OFS_CTRL, KBM_CTRL_RST);
        ec_rd(KBM_OFS_LATCH, 8'h00);
        ec_rd(KBM_OFS_STAT, KBM_STAT_RST);
        lines(8'h00);
        // command then data; third byte meets a full buffer
        host.wr(KBM_HIDX_CMD, 8'hA5);
        ec_rd(KBM_OFS_STAT, 8'h0A);
        lines(8'h08);
        host.wr(KBM_HIDX_DATA, 8'h3C);
        ec_rd(KBM_OFS_STAT, 8'h02);
        chk("host ready", 8'h00, {7'h0, hrdy});
        host.wr(KBM_HIDX_DATA, 8'h77);
        ec_rd(KBM_OFS_DATA, 8'hA5);
        ec_rd(KBM_OFS_DATA, 8'h3C);
        ec_rd(KBM_OFS_STAT, 8'h00);
        lines(8'h00);
        // gate on, aux flag in hardware
        ec_op(1'b1, KBM_OFS_CTRL, 8'hA0);
        ec_op(1'b1, KBM_OFS_DATA, 8'h11);
        ec_rd(KBM_OFS_STAT, 8'h01);
        lines(8'h04);
        ec_rd(KBM_OFS_LATCH, 8'h01);
        host.rd(KBM_HIDX_DATA, d);
        chk("host data", 8'h11, d);
        lines(8'h01);
        @(negedge mclk);
        lines(8'h00);
        ec_op(1'b1, KBM_OFS_AUX, 8'h22);
        ec_rd(KBM_OFS_STAT, 8'h21);
        lines(8'h02);
        ec_op(1'b1, KBM_OFS_DATA, 8'h33);
        ec_rd(KBM_OFS_STAT, 8'h01);
        lines(8'h06);
        host.rd(KBM_HIDX_DATA, d);
        chk("host data", 8'h33, d);
        lines(8'h01);
        // aux flag as user bit, protected status bits
        ec_op(1'b1, KBM_OFS_CTRL, 8'h20);
        ec_op(1'b1, KBM_OFS_STAT, 8'hFF);
        ec_rd(KBM_OFS_STAT, 8'hF4);
        host.rd(KBM_HIDX_CMD, d);
        chk("host status", 8'hF4, d);
        ec_op(1'b1, KBM_OFS_STAT, 8'h00);
        ec_op(1'b1, KBM_OFS_AUX, 8'h44);
        ec_rd(KBM_OFS_STAT, 8'h01);
        lines(8'h02);
        host.rd(KBM_HIDX_DATA, d);
        chk("host data", 8'h44, d);
        // firmware latch drives the keyboard source
        ec_op(1'b1, KBM_OFS_CTRL, 8'h24);
        ec_op(1'b1, KBM_OFS_LATCH, 8'hFF);
        ec_rd(KBM_OFS_LATCH, 8'h01);
        lines(8'h04);
        ec_op(1'b1, KBM_OFS_LATCH, 8'h00);
        ec_op(1'b1, KBM_OFS_DATA, 8'h55);
        lines(8'h00);
        ec_rd(KBM_OFS_LATCH, 8'h00);
        host.rd(KBM_HIDX_DATA, d);
        @(negedge mclk);
        // gate changed only while output-full is clear
        ec_op(1'b1, KBM_OFS_CTRL, 8'h00);
        ec_op(1'b1, KBM_OFS_DATA, 8'h66);
        ec_op(1'b1, KBM_OFS_AUX, 8'h67);
        lines(8'h00);
        host.rd(KBM_HIDX_DATA, d);
        chk("host data", 8'h67, d);
        // a20 gate from host, then firmware
        {a20_val, a20_wr} = 2'b11;
        @(negedge mclk);
        a20_wr = 1'b0;
        @(negedge mclk);
        chk("a20 gate", 8'h01, {7'h0, gate});
        ec_op(1'b1, KBM_OFS_CTRL, 8'h00);
        chk("a20 gate", 8'h00, {7'h0, gate});
        fw_a20 = 1'b1;
        ec_op(1'b1, KBM_OFS_CTRL, 8'h02);
        {a20_val, a20_wr} = 2'b01;
        @(negedge mclk);
        a20_wr = 1'b0;
        @(negedge mclk);
        chk("a20 gate", 8'h01, {7'h0, gate});
        // without assist only control and aux writes sample firmware level
        ec_op(1'b1, KBM_OFS_CTRL, 8'h00);
        fw_a20 = 1'b0;
        ec_op(1'b1, KBM_OFS_DATA, 8'h12);
        chk("a20 gate", 8'h01, {7'h0, gate});
        ec_op(1'b1, KBM_OFS_AUX, 8'h13);
        chk("a20 gate", 8'h00, {7'h0, gate});
        close_out();
    end
endmodule : kbm_mailbox_tb

// *** hw/kbm_buf2.sv ***
// Purpose: two-entry byte buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty are exact; drain side may stall
`timescale 1ns/1ps
module kbm_buf2
    import kbm_pkg::*;
(
    input wire logic mclk_in, // clock
    input wire logic rst_in, // sync reset
    input wire logic in_valid_in, // write strobe
    output logic in_ready_out, // room left
    input wire logic [7:0] in_data_in, // byte in
    output logic out_valid_out, // byte waiting
    input wire logic out_ready_in, // consumer takes
    output logic [7:0] out_data_out // head byte
);
    typedef struct packed {
        logic [1:0][7:0] mem;
        logic [1:0] cnt;
    } kbm_buf_st_t;

    kbm_buf_st_t st_r;
    kbm_buf_st_t st_nxt;
    logic push;
    logic pop;

    // =====================================================
    // handshakes
    assign in_ready_out = (st_r.cnt != 2'(KBM_BUF_DEPTH));
    assign out_valid_out = (st_r.cnt != 2'h0);
    assign out_data_out = st_r.mem[0];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // shift-register buffer next state
    always_comb
    begin
        st_nxt = st_r;
        if (pop)
        begin
            st_nxt.mem[0] = st_r.mem[1];
        end
        if (push)
        begin
            st_nxt.mem[(pop ? st_r.cnt - 2'h1 : st_r.cnt) == 2'h0 ? 0 : 1] = in_data_in;
        end
        st_nxt.cnt = st_r.cnt + 2'(push) - 2'(pop);
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    buf_bound_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        st_r.cnt <= 2'h2) else $error("buffer count out of range");
endmodule : kbm_buf2

// *** hw/kbm_mailbox.sv ***
// Purpose: keyboard-style byte mailbox between host and embedded controller
// Assumes: host and EC strobes are one-cycle and synchronous to mclk_in
// Notes: host-to-EC bytes pass a two-entry buffer; EC read pops it
//
// Contract
// - command write sets C/D, data clears it
// - host write sets input-full, raises EC irq
// - EC read of last buffered byte clears input-full
// - EC write either offset loads byte, sets OUTPUT_FULL_FLAG
// - host read clears OUTPUT_FULL_FLAG, pulses output-empty irq
// - aux write sets aux flag; normal clears it
// - aux hw control selects status bit 5 source
// - writes set keyboard or aux irq source
// - host read clears keyboard irq source
// - host read clears aux irq source
// - firmware select uses latch as keyboard source
// - latch reads bit0 live source, rest zero
// - gate low forces keyboard line low
// - gate low forces mouse line low
// - user status bits EC writable, host readable
// - software assist selects A20 gate source
// - irq sources reset to zero
// - EC status write keeps bits 0,1,3
`timescale 1ns/1ps
module kbm_mailbox
    import kbm_pkg::*;
(
    input wire logic mclk_in, // ec clock
    input wire logic rst_in, // system reset, high
    input wire kbm_host_req_t host_req_in, // host i/o strobe
    output logic [7:0] host_rdata_out, // host read data
    input wire kbm_ec_req_t ec_req_in, // ec bus strobe
    output logic [7:0] ec_rdata_out, // ec read data
    input wire logic host_a20_wr_in, // host-initiated a20 control
    input wire logic host_a20_val_in, // a20 level from host
    input wire logic fw_a20_val_in, // firmware a20 level
    output logic host_ready_out, // buffer accepts host write
    output logic ec_input_full_irq_out, // input-full irq to ec
    output logic ec_output_empty_irq_out, // output-empty pulse to ec
    output logic keyboard_irq_line_out, // keyboard irq to host
    output logic mouse_irq_line_out, // mouse irq to host
    output logic address_bit20_gate_out // a20 gate
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] user;
        logic [7:0] out_byte;
        logic output_full_flag;
        logic cmd_data;
        logic aux_full;
        logic kbd_src;
        logic aux_src;
        logic fw_latch;
        logic oe_pulse;
        logic a20_last;
        logic [7:0] ec_rdata;
        logic [7:0] host_rdata;
    } kbm_st_t;

    kbm_st_t st_r;
    kbm_st_t st_nxt;
    logic host_data_wr;
    logic host_cmd_wr;
    logic host_data_rd;
    logic ec_wr_data;
    logic ec_wr_aux;
    logic ec_rd_in;
    logic buf_valid;
    logic [7:0] buf_data;
    logic kbd_live;
    logic gate_en;
    logic [7:0] status;

    // =====================================================
    // request decode
    assign host_data_wr = host_req_in.wr && host_req_in.idx == KBM_HIDX_DATA;
    assign host_cmd_wr = host_req_in.wr && host_req_in.idx == KBM_HIDX_CMD;
    assign host_data_rd = host_req_in.rd && host_req_in.idx == KBM_HIDX_DATA;
    assign ec_wr_data = ec_req_in.wr && ec_req_in.addr == KBM_OFS_DATA;
    assign ec_wr_aux = ec_req_in.wr && ec_req_in.addr == KBM_OFS_AUX;
    assign ec_rd_in = ec_req_in.rd && ec_req_in.addr == KBM_OFS_DATA;
    assign gate_en = st_r.ctrl[KBM_CT_GATE];

    // =====================================================
    // host-to-ec byte buffer
    kbm_buf2 u_buf (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .in_valid_in(host_data_wr || host_cmd_wr),
        .in_ready_out(host_ready_out),
        .in_data_in(host_req_in.wdata),
        .out_valid_out(buf_valid),
        .out_ready_in(ec_rd_in),
        .out_data_out(buf_data)
    );

    // live keyboard source and status image
    always_comb
    begin
        kbd_live = st_r.ctrl[KBM_CT_FWSEL] ? st_r.fw_latch : st_r.kbd_src;
        status = st_r.user & KBM_ST_USER_MASK;
        status[KBM_ST_OBF] = st_r.output_full_flag;
        status[KBM_ST_IBF] = buf_valid;
        status[KBM_ST_CD] = st_r.cmd_data;
        status[KBM_ST_AUX] = st_r.ctrl[KBM_CT_AUX_FLAG_HW_CONTROL] ? st_r.aux_full
                                                     : st_r.user[KBM_ST_AUX];
    end

    // =====================================================
    // next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.oe_pulse = 1'b0;
        // command/data flag
        if (host_cmd_wr && host_ready_out)
            st_nxt.cmd_data = 1'b1;
        else if (host_data_wr && host_ready_out)
            st_nxt.cmd_data = 1'b0;
        // host read of output byte clears flags
        if (host_data_rd)
        begin
            st_nxt.output_full_flag = 1'b0;
            st_nxt.kbd_src = 1'b0;
            st_nxt.aux_src = 1'b0;
            st_nxt.oe_pulse = st_r.output_full_flag;
        end
        // ec writes win over same-cycle host read
        if (ec_wr_data || ec_wr_aux)
        begin
            st_nxt.out_byte = ec_req_in.wdata;
            st_nxt.output_full_flag = 1'b1;
        end
        if (ec_wr_data)
        begin
            st_nxt.aux_full = 1'b0;
            st_nxt.kbd_src = 1'b1;
        end
        if (ec_wr_aux)
        begin
            st_nxt.aux_full = 1'b1;
            st_nxt.aux_src = 1'b1;
            st_nxt.a20_last = fw_a20_val_in;
        end
        if (host_a20_wr_in)
            st_nxt.a20_last = host_a20_val_in;
        if (ec_req_in.wr)
        begin
            unique case (ec_req_in.addr)
                KBM_OFS_CTRL:
                begin
                    st_nxt.ctrl = ec_req_in.wdata;
                    st_nxt.a20_last = fw_a20_val_in;
                end
                KBM_OFS_STAT:
                    st_nxt.user = ec_req_in.wdata & (KBM_ST_USER_MASK | 8'(1 << KBM_ST_AUX));
                KBM_OFS_LATCH:
                    st_nxt.fw_latch = ec_req_in.wdata[0];
                default:
                    st_nxt.ctrl = st_nxt.ctrl;
            endcase
        end
        // ec read data
        if (ec_req_in.rd)
        begin
            unique case (ec_req_in.addr)
                KBM_OFS_DATA: st_nxt.ec_rdata = buf_data;
                KBM_OFS_STAT: st_nxt.ec_rdata = status;
                KBM_OFS_CTRL: st_nxt.ec_rdata = st_r.ctrl;
                KBM_OFS_LATCH: st_nxt.ec_rdata = {7'h00, kbd_live};
                default: st_nxt.ec_rdata = 8'h00;
            endcase
        end
        // host read data
        if (host_req_in.rd)
            st_nxt.host_rdata = host_data_rd ? st_r.out_byte : status;
    end

    // state register
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            st_r <= '0;
            st_r.ctrl <= KBM_CTRL_RST;
            st_r.user <= KBM_STAT_RST;
        end
        else
            st_r <= st_nxt;
    end

    // =====================================================
    // outputs
    assign ec_input_full_irq_out = buf_valid;
    assign ec_output_empty_irq_out = st_r.oe_pulse;
    assign keyboard_irq_line_out = gate_en && kbd_live;
    assign mouse_irq_line_out = gate_en && st_r.aux_src;
    assign address_bit20_gate_out = st_r.ctrl[KBM_CT_A20_SOFTWARE_ASSIST] ? fw_a20_val_in
                                                            : st_r.a20_last;
    assign ec_rdata_out = st_r.ec_rdata;
    assign host_rdata_out = st_r.host_rdata;

    // =====================================================
    // checks
    cd_cmd_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        host_cmd_wr && host_ready_out |=> st_r.cmd_data)
        else $error("command write left C/D clear");
    ibf_set_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (host_cmd_wr || host_data_wr) && host_ready_out |=> ec_input_full_irq_out)
        else $error("host write did not raise input-full");
    obf_set_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_wr_data || ec_wr_aux |=> st_r.output_full_flag && st_r.out_byte == $past(ec_req_in.wdata))
        else $error("ec write did not load output byte");
    obf_clr_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        host_data_rd && !ec_wr_data && !ec_wr_aux |=> !st_r.output_full_flag && !st_r.kbd_src)
        else $error("host read did not clear output full");
    aux_flag_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_wr_aux |=> st_r.aux_full ##0 st_r.aux_src)
        else $error("aux write did not set aux flags");
    keyboard_irq_line_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !gate_en |-> !keyboard_irq_line_out)
        else $error("keyboard line high while gated");
    mouse_irq_line_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_en && ec_wr_aux |=> mouse_irq_line_out)
        else $error("mouse line not raised by aux write");
    oe_pulse_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_output_empty_irq_out |=> !ec_output_empty_irq_out)
        else $error("output-empty irq longer than one cycle");
    hw_bits_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_req_in.wr && ec_req_in.addr == KBM_OFS_STAT && !host_req_in.wr
        && !host_req_in.rd && !ec_wr_data |=> $stable(st_r.output_full_flag) && $stable(st_r.cmd_data))
        else $error("status write changed hardware bits");

    // data write clears command flag
    cd_data_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        host_data_wr && host_ready_out
        |=> !st_r.cmd_data)
        else $error("data write left C/D set");

    // last byte read empties input side
    ibf_clr_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_rd_in && buf_valid && host_ready_out && !host_data_wr && !host_cmd_wr
        |=> !ec_input_full_irq_out)
        else $error("ec read did not clear input-full");

    // normal write clears aux flag
    aux_clr_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_wr_data
        |=> !st_r.aux_full)
        else $error("normal write left aux flag set");

    // normal write raises keyboard source
    kbd_set_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_wr_data
        |=> st_r.kbd_src)
        else $error("normal write did not set keyboard source");

    // host read drops keyboard line
    kbd_clr_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        host_data_rd && !ec_req_in.wr && gate_en && !st_r.ctrl[KBM_CT_FWSEL]
        |=> !keyboard_irq_line_out)
        else $error("host read left keyboard line high");

    // host read drops aux source
    aux_src_clr_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        host_data_rd && !ec_wr_aux
        |=> !st_r.aux_src)
        else $error("host read left aux source set");

    // latch read shows live source only
    latch_rd_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_req_in.rd && ec_req_in.addr == KBM_OFS_LATCH
        |=> ec_rdata_out[7:1] == 7'h00 && ec_rdata_out[0] == $past(kbd_live))
        else $error("latch read data wrong");

    // firmware select routes latch to line
    keyboard_irq_line_fw_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_en && st_r.ctrl[KBM_CT_FWSEL]
        |-> keyboard_irq_line_out == st_r.fw_latch)
        else $error("keyboard line does not follow latch");

    // hardware select routes write flag to line
    keyboard_irq_line_hw_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_en && !st_r.ctrl[KBM_CT_FWSEL]
        |-> keyboard_irq_line_out == st_r.kbd_src)
        else $error("keyboard line does not follow write flag");

    // gate off holds mouse line low
    mouse_irq_line_low_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !gate_en
        |-> !mouse_irq_line_out)
        else $error("mouse line high while gated");

    // aux write shows in status bit 5
    aux_bit_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_wr_aux && st_r.ctrl[KBM_CT_AUX_FLAG_HW_CONTROL]
        |=> status[KBM_ST_AUX])
        else $error("aux write not shown in status");

    // status bit 5 as user bit
    user_bit5_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_req_in.wr && ec_req_in.addr == KBM_OFS_STAT && !st_r.ctrl[KBM_CT_AUX_FLAG_HW_CONTROL]
        |=> status[KBM_ST_AUX] == $past(ec_req_in.wdata[KBM_ST_AUX]))
        else $error("status bit 5 not writable as user bit");

    // user bits take ec writes
    user_bits_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_req_in.wr && ec_req_in.addr == KBM_OFS_STAT
        |=> (status & KBM_ST_USER_MASK) == ($past(ec_req_in.wdata) & KBM_ST_USER_MASK))
        else $error("user status bits not written");

    // host a20 control without assist
    a20_host_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !st_r.ctrl[KBM_CT_A20_SOFTWARE_ASSIST] && host_a20_wr_in && !(ec_req_in.wr && ec_req_in.addr == KBM_OFS_CTRL)
        |=> address_bit20_gate_out == $past(host_a20_val_in))
        else $error("a20 gate ignores host control");

    // normal data write leaves a20 alone
    a20_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_wr_data && !host_a20_wr_in
        |=> $stable(st_r.a20_last))
        else $error("data write changed a20 level");

    // software assist hands gate to firmware
    a20_sw_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        st_r.ctrl[KBM_CT_A20_SOFTWARE_ASSIST]
        |-> address_bit20_gate_out == fw_a20_val_in)
        else $error("a20 gate not under firmware control");

    // output-empty pulse follows full read
    oe_rise_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        host_data_rd && st_r.output_full_flag
        |=> ec_output_empty_irq_out)
        else $error("host read gave no output-empty pulse");

    // output-empty pulse only after host read
    oe_cause_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ec_output_empty_irq_out
        |-> $past(host_data_rd))
        else $error("output-empty pulse without host read");

    cov_cmd_c: cover property (@(posedge mclk_in) host_cmd_wr ##[1:20] ec_rd_in);
    cov_out_c: cover property (@(posedge mclk_in) ec_wr_data ##[1:20] host_data_rd);
    cov_aux_c: cover property (@(posedge mclk_in) gate_en && ec_wr_aux ##1 mouse_irq_line_out);
    cov_full_c: cover property (@(posedge mclk_in) !host_ready_out);
    cov_latch_c: cover property (@(posedge mclk_in) gate_en && st_r.fw_latch && keyboard_irq_line_out);
endmodule : kbm_mailbox

// *** hw/kbm_pkg.sv ***
// Purpose: shared constants and carriers for the keyboard-style host/EC mailbox
// Assumes: EC peripheral bus with byte-wide data and 10-bit offsets
// Notes: host side reaches the block by plain index/strobe ports
package kbm_pkg;
    // =====================================================
    // ec side offsets
    localparam logic [9:0] KBM_OFS_DATA = 10'h100;
    localparam logic [9:0] KBM_OFS_STAT = 10'h104;
    localparam logic [9:0] KBM_OFS_CTRL = 10'h108;
    localparam logic [9:0] KBM_OFS_AUX = 10'h10C;
    localparam logic [9:0] KBM_OFS_LATCH = 10'h114;
    // =====================================================
    // host side indices
    localparam logic [2:0] KBM_HIDX_DATA = 3'h0;
    localparam logic [2:0] KBM_HIDX_CMD = 3'h4;
    // =====================================================
    // status bit positions
    localparam int KBM_ST_OBF = 0;
    localparam int KBM_ST_IBF = 1;
    localparam int KBM_ST_CD = 3;
    localparam int KBM_ST_AUX = 5;
    localparam logic [7:0] KBM_ST_USER_MASK = 8'hD4;
    // control bit positions
    localparam int KBM_CT_A20_SOFTWARE_ASSIST = 1;
    localparam int KBM_CT_FWSEL = 2;
    localparam int KBM_CT_GATE = 5;
    localparam int KBM_CT_AUX_FLAG_HW_CONTROL = 7;
    // reset values
    localparam logic [7:0] KBM_CTRL_RST = 8'h00;
    localparam logic [7:0] KBM_STAT_RST = 8'h00;
    localparam int KBM_BUF_DEPTH = 2;

    // host request carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] idx;
        logic [7:0] wdata;
    } kbm_host_req_t;

    // ec bus request carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } kbm_ec_req_t;
endpackage : kbm_pkg
